// file: hw/timer8_params.svh
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH

// Register offsets
`define OFS_TIMER_CONTROL_A  8'h24
`define OFS_TIMER_COUNT      8'h26
`define OFS_COMPARE_VALUE_A  8'h27
`define OFS_TIMER_IRQ_MASK   8'h28
`define OFS_TIMER_IRQ_FLAGS  8'h29

// Control field positions
`define BIT_FORCE_COMPARE    7
`define BIT_WAVE_MODE_LOW    6
`define BIT_ACTION_UPPER     5
`define BIT_ACTION_LOWER     4
`define BIT_WAVE_MODE_HIGH   3
`define BIT_CLOCK_SEL_HI     2

// Mask and flag positions
`define BIT_MATCH            1
`define BIT_WRAP             0

// Reset values
`define RST_CONTROL          8'h00
`define RST_COUNT            8'h00
`define RST_COMPARE          8'h00
`define RST_MASK             2'h0
`define RST_FLAGS            2'h0

// Counter limits
`define COUNT_MAX            8'hFF
`define COUNT_BOTTOM         8'h00

// Prescaler taps
`define TAP_DIV8             10'h007
`define TAP_DIV64            10'h03F
`define TAP_DIV256           10'h0FF
`define TAP_DIV1024          10'h3FF

`endif

// file: hw/timer8_pkg.sv
package timer8_pkg;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_PHASE_PWM,
		MODE_CLEAR_ON_MATCH,
		MODE_FAST_PWM
	} mode_type;

	typedef struct packed {
		logic       waveform_mode_low;
		logic [1:0] compare_output_action;
		logic       waveform_mode_high;
		logic [2:0] clock_source_select;
	} control_type;

	typedef struct packed {
		logic wave;
		logic pin_out;
		logic pin_oe;
	} pin_type;

	typedef struct packed {
		control_type ctrl;
		logic [7:0]  counter_value;
		logic [7:0]  compare_active;
		logic [7:0]  compare_buffer;
		logic        match_interrupt_enable;
		logic        wrap_interrupt_enable;
		logic        match_flag;
		logic        wrap_flag;
		logic        count_down;
		logic        skip_match;
		logic [9:0]  prescale;
		logic        ext_meta;
		logic        ext_sync;
		logic        ext_prev;
		logic [7:0]  rdata;
		logic        match_irq;
		logic        wrap_irq;
		pin_type     pin;
	} state_type;

endpackage : timer8_pkg

// file: hw/timer8_compare_waveform.sv
// Overview of operation
// - Force strobe works only in non-PWM modes
// - Force strobe applies current action immediately
// - Forced compare sets no flag, no clear
// - Force strobe bit always reads zero
// - Mode bits 6,3 pick mode and TOP
// - Compare update timing and wrap flag point
// - Nonzero action overrides pin; direction enables drive
// - Non-PWM actions: off, toggle, clear, set
// - Fast PWM actions with BOTTOM set/clear
// - Fast PWM compare at TOP ignored
// - Phase PWM actions by count direction
// - Phase PWM compare at TOP acts at TOP
// - Clock select stop, direct, prescaler taps
// - Codes 110/111 count external edges
// - External edges count even when pin outputs
// - Counter readable, writable; write blocks next match
// - Compare value checked against counter continuously
// - Match request needs enable, global, flag
// - Wrap request needs enable, global, flag
// - Match flag set on match, cleared
// - Wrap flag set on overflow, cleared
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "timer8_params.svh"

module timer8_compare_waveform (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       global_irq_enable_i,
	input  wire logic       match_vector_taken_i,
	input  wire logic       wrap_vector_taken_i,
	output logic            match_irq_o,
	output logic            wrap_irq_o,
	input  wire logic       ext_count_i,
	input  wire logic       port_data_i,
	input  wire logic       port_dir_out_i,
	output logic            waveform_output_o,
	output logic            waveform_output_oe_o
);

	timer8_pkg::state_type state_reg;
	timer8_pkg::state_type state_next;

	timer8_pkg::mode_type mode;
	logic       non_pwm;
	logic       wr_ctrl;
	logic       wr_count;
	logic       wr_compare;
	logic       wr_mask;
	logic       wr_flags;
	logic       tick;
	logic       at_max;
	logic       at_bottom;
	logic       match;
	logic       action_hi;
	logic       action_lo;
	logic [7:0] ctrl_byte;

	assign wr_ctrl    = wr_i && (addr_i == `OFS_TIMER_CONTROL_A);
	assign wr_count   = wr_i && (addr_i == `OFS_TIMER_COUNT);
	assign wr_compare = wr_i && (addr_i == `OFS_COMPARE_VALUE_A);
	assign wr_mask    = wr_i && (addr_i == `OFS_TIMER_IRQ_MASK);
	assign wr_flags   = wr_i && (addr_i == `OFS_TIMER_IRQ_FLAGS);

	// Mode bits are split across bit 6 and bit 3
	assign mode = timer8_pkg::mode_type'({state_reg.ctrl.waveform_mode_high,
		state_reg.ctrl.waveform_mode_low});
	assign non_pwm = (mode == timer8_pkg::MODE_NORMAL) ||
		(mode == timer8_pkg::MODE_CLEAR_ON_MATCH);

	assign action_hi = state_reg.ctrl.compare_output_action[1];
	assign action_lo = state_reg.ctrl.compare_output_action[0];

	assign at_max    = (state_reg.counter_value == `COUNT_MAX);
	assign at_bottom = (state_reg.counter_value == `COUNT_BOTTOM);

	// Continuous equality, suppressed once after a counter write
	assign match = (state_reg.counter_value == state_reg.compare_active) &&
		!state_reg.skip_match;

	// Strobe bit is never stored, so it reads as zero
	assign ctrl_byte = {1'b0, state_reg.ctrl.waveform_mode_low,
		state_reg.ctrl.compare_output_action,
		state_reg.ctrl.waveform_mode_high,
		state_reg.ctrl.clock_source_select};

	// Timer clock enable selection
	always_comb begin
		case (state_reg.ctrl.clock_source_select)
			3'h0: tick = 1'b0;
			3'h1: tick = 1'b1;
			3'h2: tick = (state_reg.prescale[2:0] == `TAP_DIV8);
			3'h3: tick = (state_reg.prescale[5:0] == `TAP_DIV64);
			3'h4: tick = (state_reg.prescale[7:0] == `TAP_DIV256);
			3'h5: tick = (state_reg.prescale == `TAP_DIV1024);
			// Pin direction is not consulted, so software may drive it
			3'h6: tick = state_reg.ext_prev && !state_reg.ext_sync;
			3'h7: tick = !state_reg.ext_prev && state_reg.ext_sync;
			default: tick = 1'b0;
		endcase
	end

	always_comb begin
		state_next = state_reg;

		// Free-running prescaler; taps are its all-ones states
		state_next.prescale = state_reg.prescale + 10'h001;

		// Synchroniser, then one stage for edge detection
		state_next.ext_meta = ext_count_i;
		state_next.ext_sync = state_reg.ext_meta;
		state_next.ext_prev = state_reg.ext_sync;

		// Counting and waveform generation
		if (tick) begin
			state_next.skip_match = 1'b0;
			case (mode)
				timer8_pkg::MODE_NORMAL: begin
					state_next.counter_value = state_reg.counter_value + 8'h01;
					if (at_max) begin
						state_next.wrap_flag = 1'b1;
					end
					if (match) begin
						case (state_reg.ctrl.compare_output_action)
							2'h1: state_next.pin.wave = !state_reg.pin.wave;
							2'h2: state_next.pin.wave = 1'b0;
							2'h3: state_next.pin.wave = 1'b1;
							default: state_next.pin.wave = state_reg.pin.wave;
						endcase
					end
				end
				timer8_pkg::MODE_CLEAR_ON_MATCH: begin
					// TOP is the compare value in this mode
					if (match) begin
						state_next.counter_value = `COUNT_BOTTOM;
					end else begin
						state_next.counter_value = state_reg.counter_value + 8'h01;
					end
					if (at_max) begin
						state_next.wrap_flag = 1'b1;
					end
					if (match) begin
						case (state_reg.ctrl.compare_output_action)
							2'h1: state_next.pin.wave = !state_reg.pin.wave;
							2'h2: state_next.pin.wave = 1'b0;
							2'h3: state_next.pin.wave = 1'b1;
							default: state_next.pin.wave = state_reg.pin.wave;
						endcase
					end
				end
				timer8_pkg::MODE_FAST_PWM: begin
					state_next.counter_value = state_reg.counter_value + 8'h01;
					if (at_max) begin
						state_next.wrap_flag = 1'b1;
						// Buffered compare loads as the count reaches BOTTOM
						state_next.compare_active = state_reg.compare_buffer;
					end
					if (action_hi) begin
						// Compare at TOP is skipped; BOTTOM action still runs
						if (match && (state_reg.compare_active != `COUNT_MAX)) begin
							state_next.pin.wave = action_lo;
						end
						if (at_max) begin
							state_next.pin.wave = !action_lo;
						end
					end
				end
				timer8_pkg::MODE_PHASE_PWM: begin
					if (state_reg.count_down) begin
						if (at_bottom) begin
							state_next.count_down = 1'b0;
							state_next.counter_value = state_reg.counter_value + 8'h01;
							state_next.wrap_flag = 1'b1;
						end else begin
							state_next.counter_value = state_reg.counter_value - 8'h01;
						end
					end else begin
						if (at_max) begin
							state_next.count_down = 1'b1;
							state_next.counter_value = state_reg.counter_value - 8'h01;
							state_next.compare_active = state_reg.compare_buffer;
						end else begin
							state_next.counter_value = state_reg.counter_value + 8'h01;
						end
					end
					if (action_hi) begin
						if (state_reg.compare_active == `COUNT_MAX) begin
							// Keeps the output symmetric about TOP
							if (at_max) begin
								state_next.pin.wave = !action_lo;
							end
						end else if (match) begin
							if (state_reg.count_down) begin
								state_next.pin.wave = !action_lo;
							end else begin
								state_next.pin.wave = action_lo;
							end
						end
					end
				end
				default: state_next.counter_value = state_reg.counter_value;
			endcase
			if (match) begin
				state_next.match_flag = 1'b1;
			end
		end

		// Clearing by write-one or vector, the wrap vector only on a cycle without a tick; a same-cycle set wins
		if ((wr_flags && wdata_i[`BIT_MATCH]) || match_vector_taken_i) begin
			state_next.match_flag = tick && match;
		end
		if ((wr_flags && wdata_i[`BIT_WRAP]) || wrap_vector_taken_i) begin
			state_next.wrap_flag = state_next.wrap_flag && tick &&
				!((wr_flags && wdata_i[`BIT_WRAP]) || wrap_vector_taken_i &&
				!state_next.wrap_flag);
			if (tick && ((mode == timer8_pkg::MODE_PHASE_PWM) ?
					(state_reg.count_down && at_bottom) : at_max)) begin
				state_next.wrap_flag = 1'b1;
			end
		end

		// Register writes
		if (wr_ctrl) begin
			state_next.ctrl.waveform_mode_low     = wdata_i[`BIT_WAVE_MODE_LOW];
			state_next.ctrl.compare_output_action =
				wdata_i[`BIT_ACTION_UPPER:`BIT_ACTION_LOWER];
			state_next.ctrl.waveform_mode_high    = wdata_i[`BIT_WAVE_MODE_HIGH];
			state_next.ctrl.clock_source_select   = wdata_i[`BIT_CLOCK_SEL_HI:0];
			// Forced match uses the action already in effect, before this write
			// is the writer's duty; the mode check covers a slip
			if (wdata_i[`BIT_FORCE_COMPARE] && non_pwm) begin
				case (state_reg.ctrl.compare_output_action)
					2'h1: state_next.pin.wave = !state_reg.pin.wave;
					2'h2: state_next.pin.wave = 1'b0;
					2'h3: state_next.pin.wave = 1'b1;
					default: state_next.pin.wave = state_reg.pin.wave;
				endcase
			end
		end
		if (wr_count) begin
			state_next.counter_value = wdata_i;
			state_next.skip_match    = 1'b1;
		end
		if (wr_compare) begin
			state_next.compare_buffer = wdata_i;
			if (non_pwm) begin
				state_next.compare_active = wdata_i;
			end
		end
		if (wr_mask) begin
			state_next.match_interrupt_enable = wdata_i[`BIT_MATCH];
			state_next.wrap_interrupt_enable  = wdata_i[`BIT_WRAP];
		end

		// Read data stands only in the cycle after the strobe
		state_next.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				`OFS_TIMER_CONTROL_A: state_next.rdata = ctrl_byte;
				`OFS_TIMER_COUNT:     state_next.rdata = state_reg.counter_value;
				`OFS_COMPARE_VALUE_A: state_next.rdata = state_reg.compare_buffer;
				`OFS_TIMER_IRQ_MASK:  state_next.rdata = {6'h00,
					state_reg.match_interrupt_enable, state_reg.wrap_interrupt_enable};
				`OFS_TIMER_IRQ_FLAGS: state_next.rdata = {6'h00,
					state_reg.match_flag, state_reg.wrap_flag};
				default:              state_next.rdata = 8'h00;
			endcase
		end

		// Requests follow the registered flags one cycle later
		state_next.match_irq = state_reg.match_interrupt_enable &&
			global_irq_enable_i && state_reg.match_flag;
		state_next.wrap_irq = state_reg.wrap_interrupt_enable &&
			global_irq_enable_i && state_reg.wrap_flag;

		// Pin mux: any nonzero action takes over the port function
		if (state_reg.ctrl.compare_output_action != 2'h0) begin
			state_next.pin.pin_out = state_reg.pin.wave;
		end else begin
			state_next.pin.pin_out = port_data_i;
		end
		state_next.pin.pin_oe = port_dir_out_i;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_reg <= '0;
			state_reg.ctrl <= timer8_pkg::control_type'(7'(`RST_CONTROL));
			state_reg.counter_value <= `RST_COUNT;
			state_reg.compare_active <= `RST_COMPARE;
			state_reg.compare_buffer <= `RST_COMPARE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_o              = state_reg.rdata;
	assign match_irq_o          = state_reg.match_irq;
	assign wrap_irq_o           = state_reg.wrap_irq;
	assign waveform_output_o    = state_reg.pin.pin_out;
	assign waveform_output_oe_o = state_reg.pin.pin_oe;

endmodule : timer8_compare_waveform

// file: testbench/timer8_chk.sv
`timescale 1ns/1ps
module timer8_chk (
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       global_irq_enable_i,
	input wire logic       match_vector_taken_i,
	input wire logic       wrap_vector_taken_i,
	input wire logic       match_irq_o,
	input wire logic       wrap_irq_o,
	input wire logic       ext_count_i,
	input wire logic       port_data_i,
	input wire logic       port_dir_out_i,
	input wire logic       waveform_output_o,
	input wire logic       waveform_output_oe_o
);
	// Shadows of control and mask, rebuilt from the bus traffic alone
	logic [7:0] ctl_reg;
	logic [1:0] msk_reg;
	logic       stopped;
	assign stopped = (ctl_reg[2:0] == 3'h0);
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ctl_reg <= 8'h00;
			msk_reg <= 2'h0;
		end else if (wr_i && addr_i == 8'h24) begin
			ctl_reg <= wdata_i;
		end else if (wr_i && addr_i == 8'h28) begin
			msk_reg <= wdata_i[1:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_match_irq_gate: assert property (match_irq_o |-> $past(global_irq_enable_i && msk_reg[1]))
		else $error("match request without its enables");
	a_wrap_irq_gate: assert property (wrap_irq_o |-> $past(global_irq_enable_i && msk_reg[0]))
		else $error("wrap request without its enables");
	a_global_off_quiet: assert property (!global_irq_enable_i |=> !match_irq_o && !wrap_irq_o)
		else $error("request while global enable low");
	// The request trails the flag by one cycle, so it drops two edges after the clear
	a_vector_clears: assert property (stopped && $past(stopped) && match_vector_taken_i |=> ##1 !match_irq_o)
		else $error("match vector did not clear request");
	a_wrap_w1c_clears: assert property (stopped && $past(stopped) && wr_i && addr_i == 8'h29 && wdata_i[0] |=> ##1 !wrap_irq_o)
		else $error("wrap write-one did not clear request");
	a_oe_follows_dir: assert property ($past(reset_n_i) |-> waveform_output_oe_o == $past(port_dir_out_i))
		else $error("output enable not following direction");
	a_pin_passthru: assert property ($past(reset_n_i) && ctl_reg[5:4] == 2'h0 && $past(ctl_reg[5:4]) == 2'h0
		|-> waveform_output_o == $past(port_data_i))
		else $error("pin not showing port data while disconnected");
	a_force_reads_zero: assert property ($past(rd_i) && $past(addr_i) == 8'h24 |-> !rdata_o[7])
		else $error("force strobe bit read as one");
	a_rdata_idle: assert property ($past(reset_n_i) && !$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its cycle");
	c_vector: cover property (match_vector_taken_i && match_irq_o);
	c_force: cover property (wr_i && addr_i == 8'h24 && wdata_i[7]);
	c_both_irq: cover property (match_irq_o && wrap_irq_o);
endmodule : timer8_chk
bind timer8_compare_waveform timer8_chk timer8_chk_i (.*);

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0, reset_n_i, wr_i, rd_i, global_irq_enable_i;
	logic match_vector_taken_i, wrap_vector_taken_i, ext_count_i, port_data_i, port_dir_out_i;
	logic [7:0] addr_i, wdata_i, rdata_o, v;
	logic match_irq_o, wrap_irq_o, waveform_output_o, waveform_output_oe_o;
	logic [15:0] h;
	int bad_count = 0, checks = 0, cyc = 0;
	timer8_compare_waveform timer8_compare_waveform_i (.*);
	always #2.5 clk_i = ~clk_i;
	task summarize;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			summarize();
		end
	end
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task rng(input string n, input int lo, input int hi, input logic [15:0] g);
		checks++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			bad_count++;
			$display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask : rng
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask : rd
	task pin(input logic e);
		repeat (2) @(posedge clk_i);
		#1 cmp("pin", {7'h00, e}, {7'h00, waveform_output_o});
	endtask : pin
	// External edges are spaced four cycles apart, well under half the clock rate
	task pulses(input logic [7:0] sel);
		wr(8'h26, 8'h00);
		wr(8'h24, sel);
		repeat (5) begin
			repeat (4) @(posedge clk_i);
			ext_count_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_count_i <= 1'b0;
		end
		repeat (6) @(posedge clk_i);
		wr(8'h24, 8'h00);
		rd(8'h26);
	endtask : pulses
	// Settling time lets the waveform run in; the compare is written in normal mode, so its active copy loads at the write
	task pwm(input logic [7:0] c, input logic [7:0] o, input int n, input int lo, input int hi);
		wr(8'h26, 8'h00);
		wr(8'h27, o);
		wr(8'h24, c);
		repeat (600) @(posedge clk_i);
		h = 16'h0000;
		repeat (n) begin
			@(posedge clk_i);
			#1 h = h + waveform_output_o;
		end
		wr(8'h24, 8'h00);
		rng("pwm high", lo, hi, h);
	endtask : pwm
	logic [7:0] ra [6] = '{8'h24, 8'h26, 8'h27, 8'h28, 8'h29, 8'h30};
	logic [7:0] fa [4] = '{8'h10, 8'h20, 8'h30, 8'h10};
	logic       fe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	int         tap [5] = '{1, 8, 64, 256, 1024};
	initial begin
		{reset_n_i, wr_i, rd_i, global_irq_enable_i, match_vector_taken_i} = 5'h00;
		{wrap_vector_taken_i, ext_count_i, port_data_i, port_dir_out_i} = 4'h1;
		{addr_i, wdata_i} = 16'h0000;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		port_data_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(ra[i]);
			cmp("reset value", 8'h00, v);
		end
		wr(8'h24, 8'hF8);
		rd(8'h24);
		cmp("control", 8'h78, v);
		wr(8'h26, 8'h5A);
		rd(8'h26);
		cmp("count", 8'h5A, v);
		wr(8'h27, 8'hC3);
		rd(8'h27);
		cmp("compare", 8'hC3, v);
		$display("registers done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h24, fa[i]);
			wr(8'h24, fa[i] | 8'h80);
			pin(fe[i]);
		end
		rd(8'h26);
		cmp("count after force", 8'h5A, v);
		rd(8'h29);
		cmp("flags after force", 8'h00, v);
		wr(8'h24, 8'h78);
		wr(8'h24, 8'hF8);
		pin(1'b0);
		wr(8'h24, 8'h70);
		wr(8'h24, 8'hF0);
		pin(1'b0);
		$display("force done");
		wr(8'h24, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(8'h26, 8'h00);
			wr(8'h24, 8'(i + 1));
			repeat (10 * tap[i] - 2) @(posedge clk_i);
			wr(8'h24, 8'h00);
			rd(8'h26);
			rng("tap count", 9, 11, {8'h00, v});
		end
		$display("clock select done");
		wr(8'h28, 8'h03);
		global_irq_enable_i <= 1'b1;
		wr(8'h26, 8'hF0);
		wr(8'h27, 8'hF5);
		wr(8'h24, 8'h01);
		repeat (40) @(posedge clk_i);
		wr(8'h24, 8'h00);
		rd(8'h29);
		cmp("flags", 8'h03, v);
		rd(8'h26);
		rng("wrapped count", 8'h19, 8'h1B, {8'h00, v});
		cmp("requests", 8'h03, {6'h00, match_irq_o, wrap_irq_o});
		global_irq_enable_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 cmp("requests masked", 8'h00, {6'h00, match_irq_o, wrap_irq_o});
		global_irq_enable_i <= 1'b1;
		@(posedge clk_i);
		match_vector_taken_i <= 1'b1;
		@(posedge clk_i);
		match_vector_taken_i <= 1'b0;
		rd(8'h29);
		cmp("flags after vector", 8'h01, v);
		wr(8'h29, 8'h01);
		rd(8'h29);
		cmp("flags after clear", 8'h00, v);
		$display("flags done");
		pulses(8'h07);
		cmp("rising edges", 8'h05, v);
		pulses(8'h06);
		cmp("falling edges", 8'h05, v);
		$display("external done");
		pwm(8'h69, 8'h40, 512, 126, 134);
		pwm(8'h79, 8'h40, 512, 378, 386);
		pwm(8'h79, 8'hFF, 512, 0, 0);
		pwm(8'h61, 8'h40, 1020, 250, 262);
		pwm(8'h71, 8'h40, 1020, 758, 770);
		pwm(8'h61, 8'hFF, 1020, 1016, 1020);
		$display("waveforms done");
		summarize();
	end
endmodule : tb
